// ---- mbs_brake_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mbs_brake_model
#(
   parameter int LAG = 5
)
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic brake_release_out,
   input  wire logic stuck,
   output logic      brake_ack_input
);
   logic [7:0] lag_cnt;

   // contact follows the coil after LAG cycles; stuck freezes it so the
   // bench can make the contact hang in either position
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lag_cnt         <= 8'h00;
         brake_ack_input <= 1'b0;
      end
      else if (stuck || brake_ack_input == brake_release_out)
         lag_cnt <= 8'h00;
      else if (lag_cnt == 8'(LAG - 1))
      begin
         lag_cnt         <= 8'h00;
         brake_ack_input <= brake_release_out;
      end
      else
         lag_cnt <= lag_cnt + 8'h01;
   end
endmodule : mbs_brake_model
`default_nettype wire

// ---- mbs_pkg.sv ----
`default_nettype none
package mbs_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_NS   = 8;
   localparam int TICK_NS  = 100_000_000;   // 0.1 s sequence tick
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   // ----------------------------------------------------------------
   // register indices, byte offset is four times the index
   // ----------------------------------------------------------------
   localparam logic [3:0] R_CTRL   = 4'h0;
   localparam logic [3:0] R_PRE    = 4'h1;
   localparam logic [3:0] R_POST   = 4'h2;
   localparam logic [3:0] R_APPLY  = 4'h3;
   localparam logic [3:0] R_SPDDLY = 4'h4;
   localparam logic [3:0] R_TPTOUT = 4'h5;
   localparam logic [3:0] R_AACKT  = 4'h6;
   localparam logic [3:0] R_RACKT  = 4'h7;
   localparam logic [3:0] R_SPDTH  = 4'h8;
   localparam logic [3:0] R_TQLVL  = 4'h9;
   localparam logic [3:0] R_CURLO  = 4'hA;
   localparam logic [3:0] R_STAT   = 4'hB;
   localparam int         N_CFG    = 11;

   // ----------------------------------------------------------------
   // control and status fields
   // ----------------------------------------------------------------
   localparam int C_SEQ    = 0;
   localparam int C_CLOSED = 1;
   localparam int C_POSH   = 2;
   localparam int C_TPEN   = 3;
   localparam int C_ACKEN  = 4;
   localparam int S_TQF    = 2;
   localparam int S_RELF   = 3;
   localparam int S_ALARM  = 4;

   // ----------------------------------------------------------------
   // reset values, delays in 0.1 s ticks, levels in 0.1 units
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] DLY_RST  = 16'h000A;
   localparam logic [15:0] TPT_RST  = 16'h0005;
   localparam logic [15:0] SPD_RST  = 16'h000A;
   localparam logic [15:0] TQL_RST  = 16'h00C8;
   localparam logic [15:0] CUR_RST  = 16'h0064;

   typedef enum logic {position_disabled_mode, rigid_feedforward_mode}
      mbs_pos_mode_t;
   typedef enum logic {pulse_generator_source, local_reference_source}
      mbs_pos_src_t;
   typedef enum logic [2:0] {st_idle, st_pre, st_rack, st_post, st_run,
      st_aack, st_adly} mbs_state_t;

   function automatic logic [15:0] mbs_cfg_rst(input int i);
      case (i)
         R_CTRL:  return CTRL_RST;
         R_TPTOUT: return TPT_RST;
         R_SPDTH: return SPD_RST;
         R_TQLVL: return TQL_RST;
         R_CURLO: return CUR_RST;
         default: return DLY_RST;
      endcase
   endfunction : mbs_cfg_rst

endpackage : mbs_pkg
`default_nettype wire

// ---- mbs_sequencer.sv ----
// Notes on behaviour
// - open loop: reversal keeps brake while running
// - closed loop: slow for apply-speed delay, then apply
// - open loop: pre-release delay under ramp hold
// - ramp hold kept through post-release delay
// - closed loop: zero speed reference until post ends
// - closed loop: apply delay holds zero speed and ramp
// - option 0: ramp hold only while inactive
// - option 1: position controller rigid, local, enabled
// - option falling: pulse source, controller disabled
// - torque proving precedes brake release
// - torque compared with proving level
// - proving timeout raises torque fault
// - torque proven status bit set
// - ack enabled: wait ack high, then post delay
// - ack enabled: wait ack low, then apply delay
// - ack disabled: delays only, input ignored
// - ack late falling sets apply alarm, hold
// - ack late rising raises release fault
// - brake output driven only when sequencing enabled
// - closed loop: low current applies brake at once
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer
   import mbs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        drive_enable,
   input  wire logic        run_reference_on,
   input  wire logic        stop_demand,
   input  wire logic [15:0] motor_speed,
   input  wire logic [15:0] out_torque,
   input  wire logic [15:0] motor_current,
   input  wire logic        brake_ack_input,
   output logic             brake_release_out,
   output logic             ramp_hold,
   output logic             zero_speed_hold,
   output logic             speed_ref_zero,
   output var mbs_pos_mode_t position_ctrl_mode,
   output var mbs_pos_src_t  position_ref_source,
   output logic             local_position_enable,
   output logic             torque_proven_status,
   output logic             torque_fault,
   output logic             release_fault,
   output logic             apply_alarm_flag
);

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   logic [15:0] cfg [N_CFG];
   wire         acc    = psel & penable;
   wire         done   = acc & pready;
   wire         wr     = done & pwrite;
   wire  [3:0]  idx    = paddr[5:2];
   wire         mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00)
                         && (idx <= R_STAT);
   wire         wr_st  = wr && mapped && (idx == R_STAT);

   wire         seq_en  = cfg[R_CTRL][C_SEQ];
   wire         closed  = cfg[R_CTRL][C_CLOSED];
   wire         posh    = cfg[R_CTRL][C_POSH];
   wire         tp_en   = cfg[R_CTRL][C_TPEN];
   wire         ack_en  = cfg[R_CTRL][C_ACKEN];

   mbs_state_t  state;
   mbs_state_t  next_state;

   wire  [15:0] stat_w = {8'h00, 3'(state), apply_alarm_flag,
                          release_fault, torque_fault,
                          torque_proven_status, brake_release_out};
   wire  [15:0] rd_w   = (idx == R_STAT) ? stat_w
                        : (mapped ? cfg[idx] : 16'h0000);

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         // one wait state: ready follows the first access cycle
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         if (acc & ~pready)
            prdata <= mapped ? {16'h0000, rd_w} : 32'h00000000;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_CFG; gi++)
      begin : g_cfg
         always_ff @(posedge mclk or posedge sys_rst)
         begin
            if (sys_rst)
               cfg[gi] <= mbs_cfg_rst(gi);
            else if (wr && mapped && (idx == 4'(gi)))
               cfg[gi] <= pwdata[15:0];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // tick and counters
   // ----------------------------------------------------------------
   logic [31:0] tdiv;
   logic        tick;
   logic [15:0] cnt;
   logic [15:0] spd_cnt;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tdiv <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (tdiv == 32'(TICK_CYCLES - 1))
      begin
         tdiv <= 32'h00000000;
         tick <= 1'b1;
      end
      else
      begin
         tdiv <= tdiv + 32'h00000001;
         tick <= 1'b0;
      end
   end

   wire spd_low  = motor_speed < cfg[R_SPDTH];
   wire cur_low  = closed && (motor_current < cfg[R_CURLO]);
   wire tq_ok    = out_torque >= cfg[R_TQLVL];
   wire proven   = torque_proven_status | tq_ok;
   wire abort    = ~drive_enable | ~run_reference_on;
   wire pre_done = closed | (cnt >= cfg[R_PRE]);
   wire tp_fail  = tp_en && !proven && (cnt >= cfg[R_TPTOUT]);
   wire rack_to  = cnt >= cfg[R_RACKT];
   wire aack_to  = cnt >= cfg[R_AACKT];
   wire spd_held = spd_cnt >= cfg[R_SPDDLY];
   // closed loop waits for a stopped demand held slow; open loop
   // keeps the brake open while the run reference stays set and stop_demand is low
   wire stop_ok  = closed ? (~run_reference_on & spd_held)
                 : (spd_low & (stop_demand | ~run_reference_on));

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt     <= 16'h0000;
         spd_cnt <= 16'h0000;
      end
      else
      begin
         if (next_state != state)
            cnt <= 16'h0000;
         else if (tick && cnt != 16'hFFFF)
            cnt <= cnt + 16'h0001;
         if (!spd_low)
            spd_cnt <= 16'h0000;
         else if (tick && spd_cnt != 16'hFFFF)
            spd_cnt <= spd_cnt + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      if (!seq_en)
         next_state = st_idle;
      else
         unique case (state)
            st_idle:
               if (drive_enable && run_reference_on)
                  next_state = st_pre;
            st_pre:
               if (abort || tp_fail)
                  next_state = st_idle;
               else if (pre_done && (!tp_en || proven))
                  next_state = st_rack;
            st_rack:
               if (abort || cur_low)
                  next_state = st_aack;
               else if (!ack_en || brake_ack_input)
                  next_state = st_post;
               else if (rack_to)
                  next_state = st_aack;
            st_post:
               if (abort || cur_low)
                  next_state = st_aack;
               else if (cnt >= cfg[R_POST])
                  next_state = st_run;
            st_run:
               if (!drive_enable || cur_low || stop_ok)
                  next_state = st_aack;
            st_aack:
               if (!ack_en || !brake_ack_input)
                  next_state = st_adly;
            st_adly:
               if (cnt >= cfg[R_APPLY])
                  next_state = st_idle;
         endcase
   end

   wire rel_n  = next_state inside {st_rack, st_post, st_run};
   wire app_n  = next_state inside {st_aack, st_adly};
   wire hold_n = seq_en && ((next_state inside {st_idle, st_pre,
                 st_rack, st_post}) || (closed && app_n));
   wire zero_n = seq_en && closed && (app_n || (next_state inside
                 {st_pre, st_rack, st_post}));

   wire tq_ev  = seq_en && state == st_pre && !abort && tp_fail;
   wire rel_ev = seq_en && state == st_rack && !abort && !cur_low
                 && ack_en && !brake_ack_input && rack_to;
   wire al_ev  = seq_en && state == st_aack && ack_en
                 && brake_ack_input && aack_to;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state                <= st_idle;
         brake_release_out    <= 1'b0;
         ramp_hold            <= 1'b0;
         zero_speed_hold      <= 1'b0;
         speed_ref_zero       <= 1'b0;
         torque_proven_status <= 1'b0;
         torque_fault         <= 1'b0;
         release_fault        <= 1'b0;
         apply_alarm_flag     <= 1'b0;
      end
      else
      begin
         state             <= next_state;
         brake_release_out <= rel_n;
         ramp_hold         <= hold_n;
         zero_speed_hold   <= seq_en && closed && app_n;
         speed_ref_zero    <= zero_n;
         torque_proven_status <= (torque_proven_status
            && next_state != st_idle) || (state == st_pre && tq_ok);
         // events win over a software clear in the same cycle
         torque_fault  <= tq_ev | (torque_fault
                          & ~(wr_st & pwdata[S_TQF]));
         release_fault <= rel_ev | (release_fault
                          & ~(wr_st & pwdata[S_RELF]));
         apply_alarm_flag <= al_ev | (apply_alarm_flag
                          & ~(wr_st & pwdata[S_ALARM]));
      end
   end

   // ----------------------------------------------------------------
   // position controller hand-off
   // ----------------------------------------------------------------
   logic posh_q;
   wire  posh_fall = posh_q & ~posh;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         posh_q                <= 1'b0;
         position_ctrl_mode    <= position_disabled_mode;
         position_ref_source   <= pulse_generator_source;
         local_position_enable <= 1'b0;
      end
      else
      begin
         posh_q <= posh;
         if (posh_fall)
         begin
            position_ctrl_mode    <= position_disabled_mode;
            position_ref_source   <= pulse_generator_source;
            local_position_enable <= 1'b0;
         end
         else if (posh)
         begin
            local_position_enable <= hold_n;
            if (hold_n)
            begin
               position_ctrl_mode  <= rigid_feedforward_mode;
               position_ref_source <= local_reference_source;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence rack_done_s;
      state == st_rack && ack_en ##1 state == st_post;
   endsequence

   sequence run_stop_s;
      state == st_run && closed && drive_enable && !cur_low
         ##1 state == st_aack;
   endsequence

   out_gated_a: assert property (!seq_en |=> !brake_release_out)
      else $error("release output set while sequencing is off");

   pre_hold_a: assert property (state == st_pre |-> ramp_hold
      && !brake_release_out)
      else $error("pre-release step without ramp hold");

   ack_rise_a: assert property (rack_done_s |-> $past(brake_ack_input))
      else $error("post delay entered without acknowledge");

   slow_held_a: assert property (run_stop_s |->
      $past(spd_held && !run_reference_on))
      else $error("closed loop brake applied before speed delay");

   cur_drop_a: assert property (state == st_run && cur_low
      && seq_en |=> !brake_release_out)
      else $error("brake not applied on low current");

   proven_set_a: assert property (state == st_pre && tq_ok
      |=> torque_proven_status)
      else $error("torque proven status not set");

   tq_fault_a: assert property ($rose(torque_fault)
      |-> $past(state == st_pre && tp_en && cnt >= cfg[R_TPTOUT]))
      else $error("torque fault without proving timeout");

   alarm_a: assert property ($rose(apply_alarm_flag)
      |-> $past(state == st_aack && brake_ack_input) ##1 zero_speed_hold
      || !closed)
      else $error("apply alarm without late acknowledge");

   apply_hold_a: assert property (state == st_adly && closed
      |-> zero_speed_hold && ramp_hold && speed_ref_zero)
      else $error("apply delay without zero-speed hold");

   lost_run_a: assert property (state inside {st_pre, st_post}
      && !run_reference_on && seq_en |=> !brake_release_out)
      else $error("release kept after run reference lost");

endmodule : mbs_sequencer
`default_nettype wire

// ---- mbs_sequencer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer_tb
   import mbs_pkg::*;
;
   localparam int TK = 10;
   typedef struct {logic [7:0] a; logic [31:0] v; logic e;} mbs_row_t;
   logic          mclk = 1'b0;
   logic          sys_rst = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0;
   logic [31:0]   prdata;
   logic          pready, pslverr, brake_ack_input, stuck = 1'b0;
   logic          drive_enable = 1'b0, run_reference_on = 1'b0;
   logic          stop_demand = 1'b0;
   logic [15:0]   motor_speed = 16'h0064, out_torque = 16'h0000;
   logic [15:0]   motor_current = 16'h01F4;
   logic          brake_release_out, ramp_hold, zero_speed_hold;
   logic          speed_ref_zero, local_position_enable;
   logic          torque_proven_status, torque_fault, release_fault;
   logic          apply_alarm_flag;
   mbs_pos_mode_t position_ctrl_mode;
   mbs_pos_src_t  position_ref_source;
   int            mismatches = 0, check_count = 0;
   // reset values: delays 1.0 s, proving 0.5 s, level 20.0 %
   mbs_row_t rows [14] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'hA, 1'b0},
      '{8'h08, 32'hA, 1'b0}, '{8'h0C, 32'hA, 1'b0}, '{8'h10, 32'hA, 1'b0},
      '{8'h14, 32'h5, 1'b0}, '{8'h18, 32'hA, 1'b0}, '{8'h1C, 32'hA, 1'b0},
      '{8'h20, 32'hA, 1'b0}, '{8'h24, 32'hC8, 1'b0}, '{8'h28, 32'h64, 1'b0},
      '{8'h2C, 32'h0, 1'b0}, '{8'h30, 32'h0, 1'b1}, '{8'hC0, 32'h0, 1'b1}};

   mbs_sequencer #(.TICK_CYCLES(TK)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_enable(drive_enable), .run_reference_on(run_reference_on),
      .stop_demand(stop_demand), .motor_speed(motor_speed),
      .out_torque(out_torque), .motor_current(motor_current),
      .brake_ack_input(brake_ack_input),
      .brake_release_out(brake_release_out), .ramp_hold(ramp_hold),
      .zero_speed_hold(zero_speed_hold), .speed_ref_zero(speed_ref_zero),
      .position_ctrl_mode(position_ctrl_mode),
      .position_ref_source(position_ref_source),
      .local_position_enable(local_position_enable),
      .torque_proven_status(torque_proven_status),
      .torque_fault(torque_fault), .release_fault(release_fault),
      .apply_alarm_flag(apply_alarm_flag));

   mbs_brake_model #(.LAG(5)) i_brake (.mclk(mclk), .sys_rst(sys_rst),
      .brake_release_out(brake_release_out), .stuck(stuck),
      .brake_ack_input(brake_ack_input));

   always #4 mclk = ~mclk;

   // ----------------------------------------------------------------
   // bus and check helpers
   // ----------------------------------------------------------------
   task automatic results;
      if (mismatches == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] x);
      check_count++;
      if (s !== x)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-drives psel at once
      @(posedge mclk);
   endtask : apb

   task automatic wr(input logic [3:0] i, input logic [15:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, {2'b00, i, 2'b00}, {16'h0000, v}, d, e);
   endtask : wr

   function automatic logic sig(input int k);
      case (k)
         0: return brake_release_out;
         1: return ramp_hold;
         2: return torque_fault;
         3: return release_fault;
         4: return apply_alarm_flag;
         default: return zero_speed_hold;
      endcase
   endfunction : sig

   task automatic waitv(input int k, input logic v, output int n);
      n = 0;
      while (sig(k) !== v && n < 2000)
      begin
         @(posedge mclk);
         n++;
      end
      if (sig(k) !== v)
         chk("wait limit", 32'(sig(k)), 32'(v));
   endtask : waitv

   initial
   begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      results();
   end

   initial
   begin
      logic [31:0] d;
      logic        e;
      int          n;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      foreach (rows[i])
      begin
         apb(1'b0, rows[i].a, 32'h0, d, e);
         chk("reg data", d, rows[i].v);
         chk("reg error", 32'(e), 32'(rows[i].e));
      end
      drive_enable     <= 1'b1;
      run_reference_on <= 1'b1;
      stuck            <= 1'b1;
      repeat (3*TK) @(posedge mclk);
      chk("seq off", 32'(brake_release_out), 32'h0);
      run_reference_on <= 1'b0;
      wr(R_PRE, 16'h0002);
      wr(R_POST, 16'h0002);
      wr(R_APPLY, 16'h0002);
      wr(R_SPDDLY, 16'h0002);
      wr(R_CTRL, 16'h0001);
      run_reference_on <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("pre ramp", 32'(ramp_hold), 32'h1);
      waitv(0, 1'b1, n);
      chk("pre span", 32'(n >= TK-2 && n <= 2*TK+2),
          32'h1);
      chk("post ramp", 32'(ramp_hold), 32'h1);
      waitv(1, 1'b0, n);
      chk("post span", 32'(n >= TK-2 && n <= 2*TK+2),
          32'h1);
      motor_speed <= 16'h0000;
      repeat (3*TK) @(posedge mclk);
      chk("reversal", 32'(brake_release_out), 32'h1);
      chk("no ack fault", 32'(release_fault), 32'h0);
      run_reference_on <= 1'b0;
      stop_demand      <= 1'b1;
      waitv(0, 1'b0, n);
      chk("stop drop", 32'(n <= 3), 32'h1);
      repeat (4*TK) @(posedge mclk);
      apb(1'b0, 8'h2C, 32'h0, d, e);
      chk("idle state", d, 32'h0);
      // closed loop with proving, position hold and acknowledge
      stuck       <= 1'b0;
      stop_demand <= 1'b0;
      motor_speed <= 16'h0064;
      out_torque  <= 16'h00C7;
      wr(R_CTRL, 16'h001F);
      run_reference_on <= 1'b1;
      repeat (3*TK) @(posedge mclk);
      chk("below level", 32'(brake_release_out), 32'h0);
      chk("zero ref", 32'(speed_ref_zero), 32'h1);
      chk("pos mode", 32'(position_ctrl_mode), 32'h1);
      chk("pos src", 32'(position_ref_source), 32'h1);
      chk("pos enable", 32'(local_position_enable), 32'h1);
      out_torque <= 16'h00C8;
      waitv(0, 1'b1, n);
      chk("prove span", 32'(n <= 4), 32'h1);
      chk("proven", 32'(torque_proven_status), 32'h1);
      waitv(1, 1'b0, n);
      chk("ack span", 32'(n >= TK+2 && n <= 2*TK+8), 32'h1);
      chk("ref freed", 32'(speed_ref_zero), 32'h0);
      motor_speed      <= 16'h0005;
      run_reference_on <= 1'b0;
      repeat (5) @(posedge mclk);
      chk("slow hold", 32'(brake_release_out), 32'h1);
      waitv(0, 1'b0, n);
      chk("slow span", 32'(n >= TK-8 && n <= 2*TK), 32'h1);
      repeat (2) @(posedge mclk);
      chk("apply zero", 32'(zero_speed_hold & ramp_hold),
          32'h1);
      waitv(5, 1'b0, n);
      chk("apply span", 32'(n >= TK+2 && n <= 2*TK+8), 32'h1);
      wr(R_CTRL, 16'h001B);
      repeat (2) @(posedge mclk);
      chk("pos off", 32'(position_ctrl_mode), 32'h0);
      chk("pos pg", 32'(position_ref_source), 32'h0);
      // low current, then proving timeout, then both contact faults
      motor_speed      <= 16'h0064;
      run_reference_on <= 1'b1;
      waitv(0, 1'b1, n);
      waitv(1, 1'b0, n);
      motor_current <= 16'h0032;
      waitv(0, 1'b0, n);
      chk("low current", 32'(n <= 2), 32'h1);
      motor_current    <= 16'h01F4;
      run_reference_on <= 1'b0;
      out_torque       <= 16'h0000;
      repeat (6*TK) @(posedge mclk);
      wr(R_TPTOUT, 16'h0001);
      run_reference_on <= 1'b1;
      waitv(2, 1'b1, n);
      chk("prove tout", 32'(n <= 2*TK+4), 32'h1);
      chk("no release", 32'(brake_release_out), 32'h0);
      run_reference_on <= 1'b0;
      out_torque       <= 16'h00C8;
      stuck            <= 1'b1;
      wr(R_RACKT, 16'h0001);
      wr(R_AACKT, 16'h0001);
      wr(R_STAT, 16'h001C);
      chk("fault clear", 32'(torque_fault), 32'h0);
      run_reference_on <= 1'b1;
      waitv(3, 1'b1, n);
      chk("rel tout", 32'(n <= 2*TK+8), 32'h1);
      run_reference_on <= 1'b0;
      stuck            <= 1'b0;
      repeat (6*TK) @(posedge mclk);
      // a one-tick release timeout could beat the contact lag
      wr(R_RACKT, 16'h000A);
      run_reference_on <= 1'b1;
      waitv(1, 1'b0, n);
      stuck            <= 1'b1;
      run_reference_on <= 1'b0;
      motor_speed      <= 16'h0005;
      waitv(4, 1'b1, n);
      chk("alarm span", 32'(n <= 5*TK), 32'h1);
      chk("alarm hold", 32'(zero_speed_hold), 32'h1);
      stuck <= 1'b0;
      repeat (4*TK) @(posedge mclk);
      results();
   end
endmodule : mbs_sequencer_tb
`default_nettype wire
